// >>> common/spr_pkg.sv
// spr_pkg: offsets, field positions and reset values of the serial port register slice
// assumes: 32-bit aligned register words reached over axi4-lite
package spr_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFS_CONTROL_MAIN = 6'h00;
  localparam logic [5:0] OFS_CONTROL_LINE = 6'h04;
  localparam logic [5:0] OFS_CONTROL_AUX = 6'h08;
  localparam logic [5:0] OFS_BAUD_DIVISOR = 6'h0C;
  localparam logic [5:0] OFS_GUARD_PRESCALE = 6'h10;
  localparam logic [5:0] OFS_RX_TIMEOUT_BLOCK_LEN = 6'h14;
  localparam logic [5:0] OFS_REQUEST_TRIGGER = 6'h18;
  localparam logic [5:0] OFS_INTERRUPT_STATUS = 6'h1C;
  localparam logic [5:0] OFS_FLAG_CLEAR = 6'h20;
  localparam logic [5:0] OFS_RX_DATA = 6'h24;
  localparam logic [5:0] OFS_TX_DATA = 6'h28;
  // ==========================================================
  // status and clear bit positions (same position in both registers)
  localparam int BIT_PARITY = 0;
  localparam int BIT_FRAMING = 1;
  localparam int BIT_NOISE = 2;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_IDLE = 4;
  localparam int BIT_RX_NOT_EMPTY = 5;
  localparam int BIT_TX_COMPLETE = 6;
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_LIN_BREAK = 8;
  localparam int BIT_CTS_CHANGE = 9;
  localparam int BIT_RX_TIMEOUT = 11;
  localparam int BIT_BLOCK_END = 12;
  localparam int BIT_CHAR_MATCH = 17;
  localparam int BIT_WAKEUP = 20;
  localparam int NUM_FLAGS = 21;
  // clearable flags with always-present features, then one mask per optional feature
  localparam logic [20:0] CLR_BASE_MASK = 21'h02005F;
  localparam logic [20:0] CLR_WAKEUP_MASK = 21'h100000;
  localparam logic [20:0] CLR_BLOCK_END_MASK = 21'h001000;
  localparam logic [20:0] CLR_RX_TIMEOUT_MASK = 21'h000800;
  localparam logic [20:0] CLR_CTS_MASK = 21'h000200;
  localparam logic [20:0] CLR_LIN_MASK = 21'h000100;
  // ==========================================================
  // control fields and reset values
  localparam int BIT_PARITY_ENABLE = 10;
  localparam int BIT_WORD_LEN9 = 28;
  localparam logic [20:0] STATUS_RESET = 21'h0000C0;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam int DATA_W = 9;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spr_pkg

// >>> logic/spr_reset_sync.sv
// spr_reset_sync: two-stage release of the asynchronous active-low reset
// assumes: rstn may drop at any time; release is taken on ref_clk
`timescale 1ns/1ps
`default_nettype none
module spr_reset_sync (
  // clock and raw reset
  input wire logic ref_clk,
  input wire logic rstn,
  // synchronised reset
  output logic rst_sync_n
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } spr_rs_state_t;
  spr_rs_state_t st, next_st;
  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.stage1 = 1'b1;
    next_st.stage2 = st.stage1;
  end
  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rst_sync_n = st.stage2;
endmodule : spr_reset_sync
`default_nettype wire

// >>> logic/spr_parity_merge.sv
// spr_parity_merge: replaces the top data bit of a character by its parity
// assumes: purely combinational, caller registers the result
`timescale 1ns/1ps
`default_nettype none
module spr_parity_merge #(
  parameter int WIDTH = 9
) (
  // character in
  input wire logic [WIDTH-1:0] char_in,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic word_len9,
  // character out
  output logic [WIDTH-1:0] char_out
);
  typedef struct packed {
    logic [WIDTH-1:0] value;
  } spr_pm_state_t;
  spr_pm_state_t next_st;
  // ==========================================================
  // parity over the bits below the top data bit
  always_comb begin
    next_st.value = char_in;
    if (parity_enable) begin
      if (word_len9) begin
        next_st.value[8] = (^char_in[7:0]) ^ parity_odd; // RQ18
      end else begin
        next_st.value[7] = (^char_in[6:0]) ^ parity_odd; // RQ18
      end
    end
  end
  assign char_out = next_st.value;
endmodule : spr_parity_merge
`default_nettype wire

// >>> logic/spr_regs.sv
// spr_regs: register slice of the asynchronous serial transceiver
// assumes: axi4-lite master on ref_clk; shift registers and flag logic on the same clock
//
// What this block does
// (RQ1) write one bit 20 clears wakeup flag
// (RQ2) write one bit 17 clears char match
// (RQ3) write one bit 12 clears block end
// (RQ4) write one bit 11 clears rx timeout
// (RQ5) write one bit 9 clears cts change
// (RQ6) write one bit 8 clears lin break
// (RQ7) write one bit 6 clears tx complete
// (RQ8) write one bit 4 clears idle flag
// (RQ9) write one bit 3 clears overrun flag
// (RQ10) write one bit 2 clears noise flag
// (RQ11) write one bit 1 clears framing error
// (RQ12) write one bit 0 clears parity error
// (RQ13) absent feature makes its clear bit inert
// (RQ14) software keeps reserved clear bits at zero
// (RQ15) rx data read-only bits 8:0, upper zero
// (RQ16) parity on: top rx bit is parity
// (RQ17) tx data bits 8:0 go to shifter
// (RQ18) parity on: top tx bit replaced
// (RQ19) software writes tx data only when empty
// (RQ20) tx data write clears empty and complete
// (RQ21) rx data read clears not-empty flag
// (RQ22) zero writes inert, flag clear reads zero
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spr_regs
  import spr_pkg::*;
#(
  parameter bit HAS_WAKEUP = 1'b1,
  parameter bit HAS_SMARTCARD = 1'b1,
  parameter bit HAS_RX_TIMEOUT = 1'b1,
  parameter bit HAS_FLOW_CONTROL = 1'b1,
  parameter bit HAS_LIN = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // axi4-lite write address
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flag set events from the transceiver, one-cycle pulses
  input wire logic [NUM_FLAGS-1:0] flag_set,
  // receive shift register hand-over
  input wire logic [DATA_W-1:0] rx_char,
  input wire logic rx_char_valid,
  // transmit shift register hand-over
  input wire logic tx_char_taken,
  output logic [DATA_W-1:0] tx_char,
  output logic tx_char_valid,
  // status and configuration to the transceiver
  output logic [NUM_FLAGS-1:0] status_flags,
  output logic [31:0] control_main,
  output logic [31:0] control_line,
  output logic [31:0] control_aux,
  output logic [31:0] baud_divisor,
  output logic [31:0] guard_prescale,
  output logic [31:0] rx_timeout_block_len,
  output logic [4:0] request_pulse
);
  // ==========================================================
  // state
  typedef struct packed {
    logic aw_held;
    logic [5:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] cr_main;
    logic [31:0] cr_line;
    logic [31:0] cr_aux;
    logic [31:0] baud;
    logic [31:0] guard;
    logic [31:0] rto;
    logic [4:0] req;
    logic [NUM_FLAGS-1:0] flags;
    logic [DATA_W-1:0] rx_value;
    logic [DATA_W-1:0] tx_value;
    logic tx_pending;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } spr_state_t;
  spr_state_t st, next_st;
  logic rst_n;
  logic [DATA_W-1:0] tx_merged;
  logic [NUM_FLAGS-1:0] clr_mask;
  logic [NUM_FLAGS-1:0] wr_clear;
  logic [NUM_FLAGS-1:0] hw_clear;
  logic do_write;
  logic do_read;
  logic [31:0] wmask;
  // ==========================================================
  // submodules
  spr_reset_sync u_rst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rst_sync_n(rst_n)
  );
  // parity computed on the written value so the shifter sees the final frame
  spr_parity_merge #(.WIDTH(DATA_W)) u_par (
    .char_in(st.w_data[DATA_W-1:0]),
    .parity_enable(st.cr_main[BIT_PARITY_ENABLE]),
    .parity_odd(st.cr_main[BIT_PARITY_ENABLE-1]),
    .word_len9(st.cr_main[BIT_WORD_LEN9]),
    .char_out(tx_merged)
  );
  // ==========================================================
  // clear-enable mask: absent features leave their clear bit inert
  always_comb begin
    clr_mask = CLR_BASE_MASK; // RQ2 RQ7 RQ8 RQ9 RQ10 RQ11 RQ12
    if (HAS_WAKEUP) begin
      clr_mask = clr_mask | CLR_WAKEUP_MASK; // RQ1 RQ13
    end
    if (HAS_SMARTCARD) begin
      clr_mask = clr_mask | CLR_BLOCK_END_MASK; // RQ3 RQ13
    end
    if (HAS_RX_TIMEOUT) begin
      clr_mask = clr_mask | CLR_RX_TIMEOUT_MASK; // RQ4 RQ13
    end
    if (HAS_FLOW_CONTROL) begin
      clr_mask = clr_mask | CLR_CTS_MASK; // RQ5 RQ13
    end
    if (HAS_LIN) begin
      clr_mask = clr_mask | CLR_LIN_MASK; // RQ6 RQ13
    end
  end
  // byte-lane write mask
  always_comb begin
    wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
  end
  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.req = '0;
    do_write = st.aw_held && st.w_held && !st.bvalid;
    do_read = s_axi_arvalid && !st.rvalid;
    wr_clear = '0;
    hw_clear = '0;
    // write address and data taken independently
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_addr == OFS_CONTROL_MAIN) begin
        next_st.cr_main = (st.cr_main & ~wmask) | (st.w_data & wmask);
      end else if (st.aw_addr == OFS_CONTROL_LINE) begin
        next_st.cr_line = (st.cr_line & ~wmask) | (st.w_data & wmask);
      end else if (st.aw_addr == OFS_CONTROL_AUX) begin
        next_st.cr_aux = (st.cr_aux & ~wmask) | (st.w_data & wmask);
      end else if (st.aw_addr == OFS_BAUD_DIVISOR) begin
        next_st.baud = (st.baud & ~wmask) | (st.w_data & wmask);
      end else if (st.aw_addr == OFS_GUARD_PRESCALE) begin
        next_st.guard = (st.guard & ~wmask) | (st.w_data & wmask);
      end else if (st.aw_addr == OFS_RX_TIMEOUT_BLOCK_LEN) begin
        next_st.rto = (st.rto & ~wmask) | (st.w_data & wmask);
      end else if (st.aw_addr == OFS_REQUEST_TRIGGER) begin
        next_st.req = st.w_data[4:0] & wmask[4:0];
      end else if (st.aw_addr == OFS_INTERRUPT_STATUS) begin
        next_st.bresp = RESP_OKAY;
      end else if (st.aw_addr == OFS_FLAG_CLEAR) begin
        // only ones clear; zeros and reserved bits do nothing
        wr_clear = st.w_data[NUM_FLAGS-1:0] & wmask[NUM_FLAGS-1:0] & clr_mask; // RQ22
      end else if (st.aw_addr == OFS_RX_DATA) begin
        next_st.bresp = RESP_OKAY;
      end else if (st.aw_addr == OFS_TX_DATA) begin
        // software must only write when empty; a late write overwrites
        next_st.tx_value = tx_merged; // RQ17 RQ18 RQ19
        next_st.tx_pending = 1'b1; // RQ17
        hw_clear[BIT_TX_EMPTY] = 1'b1; // RQ20
        hw_clear[BIT_TX_COMPLETE] = 1'b1; // RQ20
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    // read
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (do_read) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = REG_RESET;
      if (s_axi_araddr == OFS_CONTROL_MAIN) begin
        next_st.rdata = st.cr_main;
      end else if (s_axi_araddr == OFS_CONTROL_LINE) begin
        next_st.rdata = st.cr_line;
      end else if (s_axi_araddr == OFS_CONTROL_AUX) begin
        next_st.rdata = st.cr_aux;
      end else if (s_axi_araddr == OFS_BAUD_DIVISOR) begin
        next_st.rdata = st.baud;
      end else if (s_axi_araddr == OFS_GUARD_PRESCALE) begin
        next_st.rdata = st.guard;
      end else if (s_axi_araddr == OFS_RX_TIMEOUT_BLOCK_LEN) begin
        next_st.rdata = st.rto;
      end else if (s_axi_araddr == OFS_REQUEST_TRIGGER) begin
        next_st.rdata = REG_RESET;
      end else if (s_axi_araddr == OFS_INTERRUPT_STATUS) begin
        next_st.rdata = {11'h000, st.flags};
      end else if (s_axi_araddr == OFS_FLAG_CLEAR) begin
        next_st.rdata = REG_RESET; // RQ22
      end else if (s_axi_araddr == OFS_RX_DATA) begin
        // parity bit, when enabled, arrives in the top bit unaltered
        next_st.rdata = {23'h000000, st.rx_value}; // RQ15 RQ16
        hw_clear[BIT_RX_NOT_EMPTY] = 1'b1; // RQ21
      end else if (s_axi_araddr == OFS_TX_DATA) begin
        next_st.rdata = {23'h000000, st.tx_value};
      end else begin
        next_st.rresp = RESP_SLVERR;
      end
    end
    // hand-over to the transmit shifter
    if (st.tx_pending && tx_char_taken) begin
      next_st.tx_pending = 1'b0;
    end
    // receive hand-over; rx_value kept on overrun, a same-cycle read frees it
    if (rx_char_valid && (!st.flags[BIT_RX_NOT_EMPTY] || hw_clear[BIT_RX_NOT_EMPTY])) begin
      next_st.rx_value = rx_char; // RQ15 RQ16
    end
    // set wins over clear for every flag
    next_st.flags = (st.flags & ~(wr_clear | hw_clear)) | flag_set; // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6
    if (rx_char_valid) begin
      next_st.flags[BIT_RX_NOT_EMPTY] = 1'b1;
      if (st.flags[BIT_RX_NOT_EMPTY] && !hw_clear[BIT_RX_NOT_EMPTY]) begin
        next_st.flags[BIT_OVERRUN] = 1'b1;
      end
    end
    if (st.tx_pending && tx_char_taken) begin
      next_st.flags[BIT_TX_EMPTY] = 1'b1;
    end
    // readies kept in flops so the bus sees no logic after a register
    next_st.aw_rdy = !next_st.aw_held;
    next_st.w_rdy = !next_st.w_held;
    next_st.ar_rdy = !next_st.rvalid;
  end
  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.flags <= STATUS_RESET;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================================
  // outputs
  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready = st.w_rdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign tx_char = st.tx_value;
  assign tx_char_valid = st.tx_pending;
  assign status_flags = st.flags;
  assign control_main = st.cr_main;
  assign control_line = st.cr_line;
  assign control_aux = st.cr_aux;
  assign baud_divisor = st.baud;
  assign guard_prescale = st.guard;
  assign rx_timeout_block_len = st.rto;
  assign request_pulse = st.req;
endmodule : spr_regs
`default_nettype wire

// >>> tb/spr_regs_monitor.sv
// spr_regs_monitor: bus and flag relations of the register slice
// assumes: bound to spr_regs with every optional feature present
`timescale 1ns/1ps
`default_nettype none
module spr_regs_monitor
  import spr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register bus
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // transceiver side
  input wire logic [20:0] flag_set,
  input wire logic [8:0] rx_char,
  input wire logic rx_char_valid,
  input wire logic tx_char_taken,
  input wire logic [8:0] tx_char,
  input wire logic tx_char_valid,
  input wire logic [20:0] status_flags
);
  localparam logic [20:0] CLR_ALL = CLR_BASE_MASK | CLR_WAKEUP_MASK | CLR_BLOCK_END_MASK
    | CLR_RX_TIMEOUT_MASK | CLR_CTS_MASK | CLR_LIN_MASK;
  logic [5:0] wa;
  logic [5:0] ra;
  logic [20:0] wm;
  logic [8:0] rxv;
  // ==========================================
  // last address, data and received char; full strobes assumed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wa <= 6'h00;
      ra <= 6'h00;
      wm <= 21'h0;
      rxv <= 9'h000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wm <= s_axi_wdata[20:0] & CLR_ALL;
      if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
      if (rx_char_valid && (!status_flags[BIT_RX_NOT_EMPTY]
          || (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_RX_DATA))) rxv <= rx_char;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr(logic [5:0] a);
    $rose(s_axi_bvalid) && wa == a && s_axi_bresp == RESP_OKAY;
  endsequence
  sequence s_rd(logic [5:0] a);
    $rose(s_axi_rvalid) && ra == a;
  endsequence
  property p_clear;
    s_wr(OFS_FLAG_CLEAR) |-> (status_flags & wm & ~$past(flag_set)) == 21'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept after clear");
  property p_keep;
    s_wr(OFS_FLAG_CLEAR) |-> ($past(status_flags) & CLR_ALL & ~wm & ~status_flags) == 21'h0;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost on zero write");
  property p_clr_read;
    s_rd(OFS_FLAG_CLEAR) |-> s_axi_rdata == 32'h00000000;
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("clear register not zero");
  property p_rx_read;
    s_rd(OFS_RX_DATA) |-> s_axi_rdata[31:9] == 23'h0 && s_axi_rdata[8:0] == $past(rxv);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx data wrong");
  property p_rx_clear;
    s_rd(OFS_RX_DATA) ##0 !$past(rx_char_valid) |-> !status_flags[BIT_RX_NOT_EMPTY];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("not-empty kept");
  property p_tx_write;
    s_wr(OFS_TX_DATA) ##0 !$past(flag_set[BIT_TX_COMPLETE]) |->
      !status_flags[BIT_TX_EMPTY] && !status_flags[BIT_TX_COMPLETE] && tx_char_valid;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx write flags wrong");
  property p_tx_hold;
    tx_char_valid && !tx_char_taken |=> tx_char_valid && $stable(tx_char);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx char dropped");
  property p_tx_taken;
    tx_char_valid && tx_char_taken |=> !tx_char_valid && status_flags[BIT_TX_EMPTY];
  endproperty
  a_tx_taken: assert property (p_tx_taken) else $error("tx hand-over wrong");
  property p_unmapped;
    $rose(s_axi_bvalid) && wa > OFS_TX_DATA |-> s_axi_bresp == RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write accepted");
endmodule : spr_regs_monitor
bind spr_regs spr_regs_monitor mon (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .flag_set,
  .rx_char, .rx_char_valid, .tx_char_taken, .tx_char, .tx_char_valid, .status_flags);
`default_nettype wire

// >>> tb/spr_shift_model.sv
// spr_shift_model: stands in for the shift registers and flag sources
// assumes: shares ref_clk with the slice; bench calls its tasks after an edge
`timescale 1ns/1ps
`default_nettype none
module spr_shift_model (
  // clock and pacing
  input wire logic ref_clk,
  input wire logic [7:0] take_delay,
  // transmit side
  input wire logic [8:0] tx_char,
  input wire logic tx_char_valid,
  output logic tx_char_taken,
  output logic [8:0] last_tx,
  // receive side and flag events
  output logic [8:0] rx_char,
  output logic rx_char_valid,
  output logic [20:0] flag_set
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    tx_char_taken = 1'b0;
    last_tx = 9'h000;
    rx_char = 9'h000;
    rx_char_valid = 1'b0;
    flag_set = 21'h0;
  end
  // ==========================================
  // shifter load after take_delay cycles, one pulse per char
  always @(posedge ref_clk) begin
    tx_char_taken <= 1'b0;
    if (tx_char_valid && !tx_char_taken) begin
      if (cnt >= take_delay) begin
        tx_char_taken <= 1'b1;
        last_tx <= tx_char;
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
  task automatic pulse_flags(input logic [20:0] m);
    @(posedge ref_clk);
    flag_set <= m;
    @(posedge ref_clk);
    flag_set <= 21'h0;
  endtask : pulse_flags
  task automatic send_rx(input logic [8:0] c);
    @(posedge ref_clk);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    // inverted so a stale char is never mistaken for a fresh one
    rx_char <= ~c;
  endtask : send_rx
endmodule : spr_shift_model
`default_nettype wire

// >>> tb/spr_regs_test.sv
// spr_regs_test: self-checking bench for the register slice
// assumes: spr_regs with all features, shifter model beside it
`timescale 1ns/1ps
`default_nettype none
module spr_regs_test
  import spr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [20:0] flag_set, status_flags;
  logic [8:0] rx_char, tx_char, last_tx;
  logic rx_char_valid, tx_char_taken, tx_char_valid;
  logic [7:0] take_delay = 8'h14;
  int n_errors = 0;
  int checked = 0;
  spr_regs dut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flag_set, .rx_char, .rx_char_valid,
    .tx_char_taken, .tx_char, .tx_char_valid, .status_flags, .control_main(),
    .control_line(), .control_aux(), .baud_divisor(), .guard_prescale(),
    .rx_timeout_block_len(), .request_pulse());
  spr_shift_model partner (.ref_clk, .take_delay, .tx_char, .tx_char_valid,
    .tx_char_taken, .last_tx, .rx_char, .rx_char_valid, .flag_set);
  initial forever #50 ref_clk = ~ref_clk;
  // ==========================================
  // checking and bus tasks
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout;
    n_errors++;
    $display("[ERR] %0t no bus answer", $time);
    final_report;
  endtask : timeout
  // valid, ready and the answer are judged on the rising edge that moves the item
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(posedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk({30'h0, s_axi_bresp}, {30'h0, er});
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) timeout;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    d = 32'h0;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(posedge ref_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) d = s_axi_rdata;
      if (tr) chk({30'h0, s_axi_rresp}, {30'h0, er});
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) timeout;
  endtask : rd
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
    chk(d, 32'h000000C0);
    rd(OFS_FLAG_CLEAR, RESP_OKAY, d);
    chk(d, 32'h00000000);
    rd(OFS_RX_DATA, RESP_OKAY, d);
    chk(d, 32'h00000000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_clear;
    int b[12] = '{0, 1, 2, 3, 4, 6, 8, 9, 11, 12, 17, 20};
    logic [31:0] d, e;
    e = 32'h00121B5F;
    partner.pulse_flags(21'h121B5F);
    wr(OFS_FLAG_CLEAR, 32'h0, RESP_OKAY);
    rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
    chk(d & 32'h00121B5F, e);
    foreach (b[i]) begin
      wr(OFS_FLAG_CLEAR, 32'h1 << b[i], RESP_OKAY);
      rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
      e[b[i]] = 1'b0;
      chk(d & 32'h00121B5F, e);
    end
    $display("flag clear test done");
  endtask : t_clear
  task automatic t_tx;
    logic [31:0] ctl[4] = '{32'h0, 32'h00000400, 32'h00000600, 32'h10000400};
    logic [8:0] dat[4] = '{9'h1A5, 9'h0FF, 9'h07E, 9'h1FF};
    logic [31:0] d;
    logic [8:0] e, m;
    logic p;
    foreach (ctl[i]) begin
      wr(OFS_CONTROL_MAIN, ctl[i], RESP_OKAY);
      p = ctl[i][28] ? ^dat[i][7:0] : ^dat[i][6:0];
      e = dat[i];
      if (ctl[i][10] && ctl[i][28]) e[8] = p ^ ctl[i][9];
      if (ctl[i][10] && !ctl[i][28]) e[7] = p ^ ctl[i][9];
      m = (ctl[i][10] && !ctl[i][28]) ? 9'h0FF : 9'h1FF;
      partner.pulse_flags(21'h000040);
      wr(OFS_TX_DATA, {23'h0, dat[i]}, RESP_OKAY);
      rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
      chk(d & 32'hC0, 32'h0);
      d = 32'h0;
      for (int n = 0; n < 20 && d[7] !== 1'b1; n++) rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
      if (d[7] !== 1'b1) timeout;
      chk({23'h0, last_tx & m}, {23'h0, e & m});
    end
    $display("tx test done");
  endtask : t_tx
  task automatic t_rx;
    logic [31:0] d;
    partner.send_rx(9'h1A5);
    rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
    chk(d & 32'h28, 32'h20);
    rd(OFS_RX_DATA, RESP_OKAY, d);
    chk(d, 32'h000001A5);
    rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
    chk(d & 32'h20, 32'h0);
    partner.send_rx(9'h0C3);
    partner.send_rx(9'h13C);
    rd(OFS_INTERRUPT_STATUS, RESP_OKAY, d);
    chk(d & 32'h28, 32'h28);
    wr(OFS_RX_DATA, 32'h1FF, RESP_OKAY);
    rd(OFS_RX_DATA, RESP_OKAY, d);
    chk(d, 32'h000000C3);
    wr(6'h2C, 32'hFFFFFFFF, RESP_SLVERR);
    rd(6'h3C, RESP_SLVERR, d);
    s_axi_wstrb <= 4'h1;
    wr(OFS_CONTROL_LINE, 32'hA5A5A5A5, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(OFS_CONTROL_LINE, RESP_OKAY, d);
    chk(d, 32'h000000A5);
    $display("rx and refusal test done");
  endtask : t_rx
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_clear;
    t_tx;
    t_rx;
    final_report;
  end
endmodule : spr_regs_test
`default_nettype wire
